/* File: ext_memory_interface_ctrl.sv */
// external memory interface controller: registers, decode, address and selects
`timescale 1ns/1ps
`include "ext_mem_cfg.svh"

// How it works
// - throttle value n makes n of every 8 cycles unable to start access
// - monitor bit set echoes internal address bus on external address pins
// - two page registers hold address bits 28..13 appended to page accesses
// - page window accesses drive pins 8..0 from page address bits 21..13
// - in sram mode only pins 4..0 carry page bits 17..13
// - page region chip select asserts low for page window accesses
// - upper enable bit frees pins 18..15 for addressing; defaults off
// - pins 18..15 are driven high from reset
// - wait states are counted in 48 MHz periods
// - ram merge asserts ram select whenever page region select is active
// - rom merge asserts rom select whenever page region select is active
// - per-region width bit: one means 8-bit bus, zero 16-bit
// - per-region wait field selects 0 to 7 wait states
module ext_memory_interface_ctrl (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // apb register port
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [17:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output wire logic [31:0] o_prdata,
  output wire logic        o_pready,
  output wire logic        o_pslverr,
  // processor access port
  input  wire logic        i_cpu_req,
  input  wire logic        i_cpu_write,
  input  wire logic [15:0] i_cpu_addr,
  input  wire logic [15:0] i_cpu_wdata,
  output wire logic        o_cpu_ready,
  output wire logic [15:0] o_cpu_rdata,
  // external memory pins
  output wire logic [18:0] o_ext_addr,
  output wire logic [12:0] o_ext_offset,
  output wire logic [15:0] o_ext_data_out,
  output wire logic        o_ext_data_oe,
  input  wire logic [15:0] i_ext_data_in,
  output wire logic        o_ext_rd_n,
  output wire logic        o_ext_wr_n,
  output wire logic        o_page_region_chip_select_n,
  output wire logic        o_ext_ram_chip_select_n,
  output wire logic        o_ext_rom_chip_select_n,
  output wire logic        o_ext_byte_bus
);
  logic [15:0]          page1_q;
  logic [15:0]          page2_q;
  logic                 upper_en_q;
  logic [13:0]          timing_q;
  logic [2:0]           arb_dead_q;
  logic                 monitor_q;
  logic                 sram_mode_q;
  logic [31:0]          prdata_q;
  ext_mem_pkg::region_t rgn_d;
  ext_mem_pkg::region_t rgn_q;
  logic                 busy_q;
  logic                 write_q;
  logic                 byte_d;
  logic                 byte_q;
  logic [2:0]           wait_d;
  logic [15:0]          wdata_q;
  logic [15:0]          rdata_q;
  logic [14:0]          addr_lo_q;
  logic [3:0]           addr_hi_q;
  logic [12:0]          offset_q;
  logic [15:0]          page_sel;
  logic [8:0]           page_pins;
  logic [15:0]          apb_idx;
  logic                 apb_setup;
  logic                 apb_access;
  logic                 apb_write;
  logic                 arb_avail;
  logic                 start;
  logic                 stb;

  ext_access_if acc ();

  function automatic ext_mem_pkg::region_t region_of(input logic [2:0] win);
    case (win)
      `WIN_RAM_LO, `WIN_RAM_HI: region_of = ext_mem_pkg::RGN_RAM;
      `WIN_PAGE1, `WIN_PAGE2:   region_of = ext_mem_pkg::RGN_PAGE;
      `WIN_ROM:                 region_of = ext_mem_pkg::RGN_ROM;
      default:                  region_of = ext_mem_pkg::RGN_NONE;
    endcase
  endfunction

  function automatic logic mapped(input logic [15:0] idx);
    mapped = (idx == `IDX_PAGE1) || (idx == `IDX_PAGE2) || (idx == `IDX_UPPER) ||
             (idx == `IDX_TIMING) || (idx == `IDX_DIAG) || (idx == `IDX_PORT_MODE);
  endfunction

  // apb slave: zero wait states, error on unmapped index
  assign apb_idx    = i_paddr[17:2];
  assign apb_setup  = i_psel & ~i_penable;
  assign apb_access = i_psel & i_penable;
  assign apb_write  = apb_access & i_pwrite & mapped(apb_idx);
  assign o_pready   = apb_access;
  assign o_pslverr  = apb_access & ~mapped(apb_idx);
  assign o_prdata   = prdata_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      page1_q <= `PAGE_RST;
      page2_q <= `PAGE_RST;
    end else if (apb_write && (apb_idx == `IDX_PAGE1)) begin
      page1_q <= i_pwdata[15:0];
    end else if (apb_write && (apb_idx == `IDX_PAGE2)) begin
      page2_q <= i_pwdata[15:0];
    end
  end

  // reserved bits are not stored, so they cannot steer anything
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      upper_en_q <= `UPPER_RST;
    end else if (apb_write && (apb_idx == `IDX_UPPER)) begin
      upper_en_q <= i_pwdata[`UPPER_EN_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      timing_q <= `TIMING_RST;
    end else if (apb_write && (apb_idx == `IDX_TIMING)) begin
      timing_q <= i_pwdata[`TIMING_HI:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      arb_dead_q <= `ARB_RST;
      monitor_q  <= `MONITOR_RST;
    end else if (apb_write && (apb_idx == `IDX_DIAG)) begin
      arb_dead_q <= i_pwdata[`ARB_HI:`ARB_LO];
      monitor_q  <= i_pwdata[`MONITOR_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sram_mode_q <= `SRAM_MODE_RST;
    end else if (apb_write && (apb_idx == `IDX_PORT_MODE)) begin
      sram_mode_q <= i_pwdata[`SRAM_MODE_BIT];
    end
  end

  // read data is captured in the setup phase and shown in the access phase
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prdata_q <= 32'h00000000;
    end else if (apb_setup) begin
      case (apb_idx)
        `IDX_PAGE1:     prdata_q <= {16'h0000, page1_q};
        `IDX_PAGE2:     prdata_q <= {16'h0000, page2_q};
        `IDX_UPPER:     prdata_q <= 32'(upper_en_q) << `UPPER_EN_BIT;
        `IDX_TIMING:    prdata_q <= 32'(timing_q);
        `IDX_PORT_MODE: prdata_q <= (32'(busy_q) << `BUSY_BIT) |
                                    (32'(sram_mode_q) << `SRAM_MODE_BIT);
        default:        prdata_q <= 32'h00000000;
      endcase
    end
  end

  arb_throttle u_throttle (
    .i_clk        (i_clk),
    .i_resetn     (i_resetn),
    .i_dead_count (arb_dead_q),
    .o_avail      (arb_avail)
  );

  ext_access_seq u_seq (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .acc      (acc)
  );

  // access decode and start
  assign rgn_d     = region_of(i_cpu_addr[15:13]);
  assign page_sel  = i_cpu_addr[13] ? page2_q : page1_q;
  assign page_pins = sram_mode_q ? {4'h0, page_sel[4:0]} : page_sel[8:0];
  assign start     = i_cpu_req & ~busy_q & arb_avail;

  always_comb begin
    wait_d = 3'h0;
    byte_d = 1'b0;
    case (rgn_d)
      ext_mem_pkg::RGN_RAM: begin
        wait_d = timing_q[`RAM_WAIT_HI:`RAM_WAIT_LO];
        byte_d = timing_q[`RAM_BYTE_BIT];
      end
      ext_mem_pkg::RGN_ROM: begin
        wait_d = timing_q[`ROM_WAIT_HI:`ROM_WAIT_LO];
        byte_d = timing_q[`ROM_BYTE_BIT];
      end
      ext_mem_pkg::RGN_PAGE: begin
        wait_d = timing_q[`PAGE_WAIT_HI:`PAGE_WAIT_LO];
        byte_d = timing_q[`PAGE_BYTE_BIT];
      end
      default: begin
        wait_d = 3'h0;
      end
    endcase
  end

  assign acc.start    = start;
  assign acc.wait_sel = wait_d;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
    end else if (acc.done) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rgn_q    <= ext_mem_pkg::RGN_NONE;
      write_q  <= 1'b0;
      byte_q   <= 1'b0;
      wdata_q  <= 16'h0000;
      offset_q <= 13'h0000;
    end else if (start) begin
      rgn_q    <= rgn_d;
      write_q  <= i_cpu_write;
      byte_q   <= byte_d;
      wdata_q  <= i_cpu_wdata;
      offset_q <= i_cpu_addr[12:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 16'h0000;
    end else if (acc.last && !write_q) begin
      rdata_q <= i_ext_data_in;
    end
  end

  // monitor mode overrides the access address every cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      addr_lo_q <= 15'h0000;
    end else if (monitor_q) begin
      addr_lo_q <= i_cpu_addr[14:0];
    end else if (start) begin
      if (rgn_d == ext_mem_pkg::RGN_PAGE) begin
        addr_lo_q <= {6'h00, page_pins};
      end else begin
        addr_lo_q <= i_cpu_addr[14:0];
      end
    end
  end

  // upper pins idle high until enabled; a freshly enabled bus waits for an access
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      addr_hi_q <= `UPPER_IDLE;
    end else if (monitor_q) begin
      addr_hi_q <= {3'h0, i_cpu_addr[15]};
    end else if (!upper_en_q) begin
      addr_hi_q <= `UPPER_IDLE;
    end else if (start) begin
      addr_hi_q <= (rgn_d == ext_mem_pkg::RGN_PAGE) ? page_sel[15:12] : 4'h0;
    end
  end

  // strobes and selects; accesses outside every window complete silently
  assign stb            = acc.strobe & (rgn_q != ext_mem_pkg::RGN_NONE);
  assign o_ext_rd_n     = ~(stb & ~write_q);
  assign o_ext_wr_n     = ~(stb & write_q);
  assign o_ext_data_oe  = stb & write_q;
  assign o_ext_data_out = wdata_q;
  assign o_ext_addr     = {addr_hi_q, addr_lo_q};
  assign o_ext_offset   = offset_q;
  assign o_ext_byte_bus = byte_q;
  assign o_cpu_ready    = acc.done;
  assign o_cpu_rdata    = rdata_q;
  assign o_page_region_chip_select_n = ~(stb & (rgn_q == ext_mem_pkg::RGN_PAGE));
  assign o_ext_ram_chip_select_n = ~(stb & ((rgn_q == ext_mem_pkg::RGN_RAM) ||
    (timing_q[`RAM_MERGE_BIT] && (rgn_q == ext_mem_pkg::RGN_PAGE))));
  assign o_ext_rom_chip_select_n = ~(stb & ((rgn_q == ext_mem_pkg::RGN_ROM) ||
    (timing_q[`ROM_MERGE_BIT] && (rgn_q == ext_mem_pkg::RGN_PAGE))));

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_echo;
    monitor_q && $past(monitor_q) |-> o_ext_addr == {3'h0, $past(i_cpu_addr)};
  endproperty
  a_echo: assert property (p_echo) else $error("address not echoed");

  property p_upper_off;
    !upper_en_q && !monitor_q && !$past(upper_en_q) && !$past(monitor_q)
      |-> o_ext_addr[18:15] == 4'hF;
  endproperty
  a_upper_off: assert property (p_upper_off) else $error("upper pins not high");

  property p_page_pins;
    start && (rgn_d == ext_mem_pkg::RGN_PAGE) && !monitor_q && !sram_mode_q
      |=> monitor_q || (o_ext_addr[8:0] == $past(page_sel[8:0]));
  endproperty
  a_page_pins: assert property (p_page_pins) else $error("page pins wrong");

  property p_sram_pins;
    start && (rgn_d == ext_mem_pkg::RGN_PAGE) && !monitor_q && sram_mode_q
      |=> monitor_q || (o_ext_addr[8:5] == 4'h0);
  endproperty
  a_sram_pins: assert property (p_sram_pins) else $error("sram mode uses high pins");

  property p_page_cs;
    start && (rgn_d == ext_mem_pkg::RGN_PAGE) |=> !o_page_region_chip_select_n;
  endproperty
  a_page_cs: assert property (p_page_cs) else $error("page select missing");

  property p_ram_merge;
    !o_page_region_chip_select_n
      |-> o_ext_ram_chip_select_n == !timing_q[`RAM_MERGE_BIT];
  endproperty
  a_ram_merge: assert property (p_ram_merge) else $error("ram merge wrong");

  property p_rom_merge;
    !o_page_region_chip_select_n
      |-> o_ext_rom_chip_select_n == !timing_q[`ROM_MERGE_BIT];
  endproperty
  a_rom_merge: assert property (p_rom_merge) else $error("rom merge wrong");

  property p_byte;
    start && (rgn_d == ext_mem_pkg::RGN_RAM) ##1 $stable(timing_q)
      |-> o_ext_byte_bus == timing_q[`RAM_BYTE_BIT];
  endproperty
  a_byte: assert property (p_byte) else $error("ram width wrong");

  property p_zero_wait;
    start && (rgn_d == ext_mem_pkg::RGN_RAM) && (wait_d == 3'h0)
      |=> !o_ext_ram_chip_select_n ##1 o_cpu_ready;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("zero wait access wrong");
endmodule

/* File: ext_mem_cfg.svh */
// constants for the external memory interface controller
`ifndef EXT_MEM_CFG_SVH
`define EXT_MEM_CFG_SVH
// register indices; the apb byte address is four times the index
`define IDX_PAGE1       16'hC018
`define IDX_PAGE2       16'hC01A
`define IDX_UPPER       16'hC038
`define IDX_TIMING      16'hC03A
`define IDX_DIAG        16'hC03E
`define IDX_PORT_MODE   16'hC040
// field positions
`define UPPER_EN_BIT    3
`define RAM_MERGE_BIT   13
`define ROM_MERGE_BIT   12
`define PAGE_BYTE_BIT   11
`define PAGE_WAIT_HI    10
`define PAGE_WAIT_LO    8
`define ROM_BYTE_BIT    7
`define ROM_WAIT_HI     6
`define ROM_WAIT_LO     4
`define RAM_BYTE_BIT    3
`define RAM_WAIT_HI     2
`define RAM_WAIT_LO     0
`define TIMING_HI       13
`define ARB_HI          10
`define ARB_LO          8
`define MONITOR_BIT     0
`define SRAM_MODE_BIT   0
`define BUSY_BIT        8
// reset values
`define PAGE_RST        16'h0000
`define UPPER_RST       1'h0
`define TIMING_RST      14'h0000
`define ARB_RST         3'h0
`define MONITOR_RST     1'h0
`define SRAM_MODE_RST   1'h0
`define UPPER_IDLE      4'hF
// cpu windows, word address bits [15:13]
`define WIN_RAM_LO      3'h2
`define WIN_RAM_HI      3'h3
`define WIN_PAGE1       3'h4
`define WIN_PAGE2       3'h5
`define WIN_ROM         3'h7
// clock rates in MHz: system clock 25, wait state base 48
`define SYS_CLK_MHZ     8'h19
`define WAIT_CLK_MHZ    8'h30
`endif

/* File: ext_mem_pkg.sv */
// types shared by the external memory interface controller
`include "ext_mem_cfg.svh"
package ext_mem_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE   = 3'h1,
    SEQ_STROBE = 3'h2,
    SEQ_DONE   = 3'h4
  } seq_state_t;

  typedef enum logic [3:0] {
    RGN_NONE = 4'h1,
    RGN_RAM  = 4'h2,
    RGN_ROM  = 4'h4,
    RGN_PAGE = 4'h8
  } region_t;

  // system cycles covering n wait states of the 48 MHz base, rounded up
  function automatic logic [2:0] wait_cycles(input logic [2:0] n);
    logic [7:0] t;
    t = (({5'h00, n} * `SYS_CLK_MHZ) + `WAIT_CLK_MHZ - 8'h01) / `WAIT_CLK_MHZ;
    return t[2:0];
  endfunction
endpackage

/* File: ext_access_if.sv */
// handshake between the controller and its strobe sequencer
`timescale 1ns/1ps
interface ext_access_if;
  logic       start;
  logic [2:0] wait_sel;
  logic       strobe;
  logic       last;
  logic       done;
  modport ctrl (output start, output wait_sel, input strobe, input last, input done);
  modport seq  (input start, input wait_sel, output strobe, output last, output done);
endinterface

/* File: arb_throttle.sv */
// memory arbitration throttle: blocks a number of cycles in each round of eight
`timescale 1ns/1ps
module arb_throttle (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // dead cycles per round and availability
  input  wire logic [2:0] i_dead_count,
  output wire logic       o_avail
);
  logic [2:0] phase_q;
  logic [3:0] avail_cnt_q;
  logic [2:0] dead_prev_q;
  logic       stable_q;

  // the first n phases of each round are dead
  assign o_avail = (phase_q >= i_dead_count);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_q <= 3'h0;
    end else begin
      phase_q <= phase_q + 3'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      avail_cnt_q <= 4'h0;
      dead_prev_q <= 3'h0;
      stable_q    <= 1'b0;
    end else begin
      dead_prev_q <= i_dead_count;
      if (phase_q == 3'h0) begin
        avail_cnt_q <= {3'h0, o_avail};
        stable_q    <= 1'b1;
      end else begin
        avail_cnt_q <= avail_cnt_q + {3'h0, o_avail};
        if (i_dead_count != dead_prev_q) begin
          stable_q <= 1'b0;
        end
      end
    end
  end

  property p_round;
    @(posedge i_clk) disable iff (!i_resetn)
    (phase_q == 3'h7) && stable_q && (i_dead_count == dead_prev_q)
      |-> (avail_cnt_q + {3'h0, o_avail}) == (4'h8 - {1'b0, i_dead_count});
  endproperty
  a_round: assert property (p_round) else $error("wrong available cycles in round");
endmodule

/* File: ext_access_seq.sv */
// access strobe sequencer: one base cycle plus the selected wait states
`timescale 1ns/1ps
module ext_access_seq (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // handshake toward the controller
  ext_access_if.seq acc
);
  ext_mem_pkg::seq_state_t state_q;
  logic [2:0] cnt_q;
  logic [2:0] exp_q;
  logic [3:0] len_q;

  assign acc.strobe = (state_q == ext_mem_pkg::SEQ_STROBE);
  assign acc.last   = acc.strobe && (cnt_q == 3'h0);
  assign acc.done   = (state_q == ext_mem_pkg::SEQ_DONE);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ext_mem_pkg::SEQ_IDLE;
    end else begin
      case (state_q)
        ext_mem_pkg::SEQ_IDLE: begin
          if (acc.start) begin
            state_q <= ext_mem_pkg::SEQ_STROBE;
          end
        end
        ext_mem_pkg::SEQ_STROBE: begin
          if (cnt_q == 3'h0) begin
            state_q <= ext_mem_pkg::SEQ_DONE;
          end
        end
        ext_mem_pkg::SEQ_DONE: begin
          state_q <= ext_mem_pkg::SEQ_IDLE;
        end
        default: begin
          state_q <= ext_mem_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // wait states are counted in 48 MHz periods, converted to system cycles
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= 3'h0;
    end else if ((state_q == ext_mem_pkg::SEQ_IDLE) && acc.start) begin
      cnt_q <= ext_mem_pkg::wait_cycles(acc.wait_sel);
    end else if (acc.strobe && (cnt_q != 3'h0)) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end

  // checking aid: expected and measured strobe length
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      exp_q <= 3'h0;
      len_q <= 4'h0;
    end else if ((state_q == ext_mem_pkg::SEQ_IDLE) && acc.start) begin
      exp_q <= ext_mem_pkg::wait_cycles(acc.wait_sel);
      len_q <= 4'h0;
    end else if (acc.strobe) begin
      len_q <= len_q + 4'h1;
    end
  end

  sequence s_begin;
    (state_q == ext_mem_pkg::SEQ_IDLE) && acc.start;
  endsequence
  sequence s_end;
    acc.done;
  endsequence

  property p_bounded;
    @(posedge i_clk) disable iff (!i_resetn) s_begin |-> ##[2:6] s_end;
  endproperty
  a_bounded: assert property (p_bounded) else $error("access did not complete");

  property p_len;
    @(posedge i_clk) disable iff (!i_resetn) acc.done |-> len_q == ({1'b0, exp_q} + 4'h1);
  endproperty
  a_len: assert property (p_len) else $error("strobe length wrong");

  property p_wait7;
    @(posedge i_clk) disable iff (!i_resetn)
    s_begin and (acc.wait_sel == 3'h7) |-> ##1 acc.strobe [*5] ##1 s_end;
  endproperty
  a_wait7: assert property (p_wait7) else $error("seven waits not five cycles");

  property p_done_pulse;
    @(posedge i_clk) disable iff (!i_resetn) acc.done |=> !acc.done && !acc.strobe;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");
endmodule

/* File: sram_model.sv */
// behavioural external sram on the far side of the memory pins
`timescale 1ns/1ps
module sram_model (
  // pins from the controller
  input  wire logic        i_clk,
  input  wire logic [18:0] i_a,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_oe,
  input  wire logic        i_cs_n,
  input  wire logic [15:0] i_d,
  // data pins toward the controller
  output logic      [15:0] o_d
);
  logic [15:0] mem [256];
  logic [15:0] last_q = 16'h0000;
  always @(posedge i_clk) begin
    if (!i_cs_n && !i_wr_n && i_oe) begin
      mem[i_a[7:0]] <= i_d;
    end
    last_q <= o_d;
  end
  // a released bus toggles so a stale word can never pass for a read
  assign o_d = (!i_cs_n && !i_rd_n) ? mem[i_a[7:0]] : ~last_q;
endmodule

/* File: tb_ext_memory_interface_ctrl.sv */
// self-checking bench for the external memory interface controller
`timescale 1ns/1ps
`include "ext_mem_cfg.svh"
module tb_ext_memory_interface_ctrl;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic        req = 1'b0;
  logic        wr = 1'b0;
  logic [15:0] ca = '0;
  logic [15:0] cd = '0;
  logic [31:0] prdata;
  logic        pready, pslverr, rdy, oe, rd_n, wr_n, pcs_n, ramcs_n, romcs_n, bb;
  logic [15:0] rdata, dout, din, erd, p1, p2, d, a;
  logic [15:0] dv [8];
  logic [18:0] ea;
  logic [12:0] off;
  logic [32:0] exp_apb[$];
  logic [56:0] exp_cpu[$];
  logic [56:0] e;
  logic [22:0] got;
  logic [3:0]  cnt = '0;
  logic        pend = 1'b0;
  int          fails = 0, num_checks = 0, cyc = 0, lastr = 0, gap = 0, n;
  integer      seed;

  always #20 i_clk = ~i_clk;

  ext_memory_interface_ctrl DUT (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_cpu_req(req), .i_cpu_write(wr),
    .i_cpu_addr(ca), .i_cpu_wdata(cd), .o_cpu_ready(rdy), .o_cpu_rdata(rdata),
    .o_ext_addr(ea), .o_ext_offset(off), .o_ext_data_out(dout), .o_ext_data_oe(oe),
    .i_ext_data_in(din), .o_ext_rd_n(rd_n), .o_ext_wr_n(wr_n),
    .o_page_region_chip_select_n(pcs_n), .o_ext_ram_chip_select_n(ramcs_n),
    .o_ext_rom_chip_select_n(romcs_n), .o_ext_byte_bus(bb));

  sram_model far (.i_clk(i_clk), .i_a(ea), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_oe(oe),
    .i_cs_n(pcs_n & ramcs_n & romcs_n), .i_d(dout), .o_d(din));

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    num_checks++;
    if (g !== x) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic hang();
    fails++;
    summarize();
  endtask

  task automatic apb(input logic w_, input logic [15:0] idx, input logic [31:0] wd,
                     input logic [32:0] ex);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w_;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    if (!w_)
      exp_apb.push_back(ex);
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      hang();
  endtask

  // pins holds expected {address, page/ram/rom selects, byte bus}; offset leads the note
  task automatic cpu(input logic w_, input logic [15:0] ad, input logic [15:0] dd,
                     input int wt, input logic [22:0] pins);
    exp_cpu.push_back({ad[12:0], 4'(1 + (wt * 25 + 47) / 48), pins, ~w_, dd});
    @(posedge i_clk);
    req <= 1'b1;
    wr <= w_;
    ca <= ad;
    cd <= dd;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    req <= 1'b0;
    if (n >= 50)
      hang();
  endtask

  always @(posedge i_clk)
    if (psel && penable && !pwrite && pready === 1'b1)
      chk({pslverr, prdata}, exp_apb.pop_front());

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    pend <= 1'b0;
    if (rd_n === 1'b0 || wr_n === 1'b0) begin
      cnt <= cnt + 4'h1;
      got <= {ea, pcs_n, ramcs_n, romcs_n, bb};
    end
    if (pend)
      chk(33'(rdata), 33'(erd));
    if (rdy === 1'b1) begin
      e = exp_cpu.pop_front();
      chk(33'({cnt, got}), 33'(e[43:17]));
      chk(33'(off), 33'(e[56:44]));
      cnt <= 4'h0;
      gap <= cyc - lastr;
      lastr <= cyc;
      pend <= e[16];
      erd <= e[15:0];
    end
  end

  initial begin
    seed = 32'h967B;
    repeat (4) @(posedge i_clk);
    chk(33'({ea, pcs_n, ramcs_n, romcs_n}), 33'({19'h78000, 3'h7}));
    i_resetn <= 1'b1;
    // page bit 21 kept low so page accesses go external
    p1 = 16'($random(seed)) & 16'hFEFF;
    p2 = 16'($random(seed)) & 16'hFEFF;
    apb(1'b1, `IDX_PAGE1, 32'(p1), '0);
    apb(1'b0, `IDX_PAGE1, '0, 33'(p1));
    apb(1'b1, `IDX_PAGE2, 32'(p2), '0);
    apb(1'b0, `IDX_PAGE2, '0, 33'(p2));
    apb(1'b0, `IDX_UPPER, '0, '0);
    apb(1'b1, `IDX_DIAG, 32'h0500, '0);
    apb(1'b0, `IDX_DIAG, '0, '0);
    apb(1'b0, 16'hC000, '0, 33'h1_0000_0000);
    apb(1'b1, `IDX_DIAG, '0, '0);
    for (int w = 0; w < 8; w++) begin
      dv[w] = 16'($random(seed));
      a = {13'h0800, w[2:0]};
      apb(1'b1, `IDX_TIMING, 32'({w[0], w[2:0]}), '0);
      cpu(1'b1, a, dv[w], w, {4'hF, a[14:0], 3'h5, w[0]});
      cpu(1'b0, a, dv[w], w, {4'hF, a[14:0], 3'h5, w[0]});
    end
    apb(1'b1, `IDX_TIMING, 32'h00D0, '0);
    cpu(1'b0, 16'hE003, dv[3], 5, {4'hF, 15'h6003, 3'h6, 1'b1});
    $display("ram and rom accesses done");
    apb(1'b1, `IDX_UPPER, 32'h8, '0);
    apb(1'b0, `IDX_UPPER, '0, 33'h8);
    cpu(1'b0, 16'h4007, dv[7], 0, {4'h0, 15'h4007, 3'h5, 1'b0});
    for (int t = 0; t < 2; t++) begin
      apb(1'b1, `IDX_DIAG, t ? 32'h0700 : 32'h0, '0);
      repeat (2)
        cpu(1'b0, 16'h4001, dv[1], 0, {4'h0, 15'h4001, 3'h5, 1'b0});
      @(posedge i_clk);
      chk(33'(gap), t ? 33'd8 : 33'd4);
    end
    apb(1'b1, `IDX_DIAG, '0, '0);
    $display("throttle done");
    d = 16'($random(seed));
    apb(1'b1, `IDX_TIMING, 32'h2B00, '0);
    cpu(1'b1, 16'h8005, d, 3, {p1[15:12], 6'h0, p1[8:0], 3'h1, 1'b1});
    apb(1'b1, `IDX_TIMING, 32'h1000, '0);
    cpu(1'b1, 16'hA001, d, 0, {p2[15:12], 6'h0, p2[8:0], 3'h2, 1'b0});
    apb(1'b1, `IDX_PORT_MODE, 32'h1, '0);
    cpu(1'b1, 16'h8002, d, 0, {p1[15:12], 10'h0, p1[4:0], 3'h2, 1'b0});
    $display("page accesses done");
    apb(1'b1, `IDX_DIAG, 32'h1, '0);
    ca <= d;
    repeat (2) @(posedge i_clk);
    chk(33'(ea), 33'({3'h0, d}));
    $display("address echo done");
    summarize();
  end
endmodule
